// ---- verilog/cstg_top.sv ----
// self-test sequencer and error-state gate for an encrypting drive
// assumes test engines, rng sources, host link and nv record share clock_i
`timescale 1ns/1ps
`include "cstg_cfg.svh"

module cstg_top #(
  parameter int DATA_W = 32,
  parameter int RNG_W = 64,
  parameter int LOGIN_LIMIT = `CSTG_LOGIN_LIMIT
) (
  input wire logic clock_i, // 200 mhz
  input wire logic srst_i, // power-on reset
  input wire cstg_pkg::cstg_nv_s nv_rec_i, // stored fault record
  output cstg_pkg::cstg_nv_s nv_rec_o, // fault record to store
  output logic nv_wr_o, // store pulse
  output logic test_start_o, // start pulse to test engine
  output logic [2:0] test_sel_o, // test being run
  input wire logic test_done_i, // engine finished pulse
  input wire logic test_pass_i, // engine result with done
  input wire logic deterministic_random_generator_valid_i, // generator word valid
  input wire logic [RNG_W-1:0] deterministic_random_generator_data_i, // deterministic_random_generator word
  input wire logic noise_valid_i, // noise word valid
  input wire logic [RNG_W-1:0] noise_data_i, // nondeterministic_noise_source word
  input wire logic host_rx_valid_i, // data from host
  input wire logic [DATA_W-1:0] host_rx_data_i, // data from host
  output logic core_rx_valid_o, // data to core
  output logic [DATA_W-1:0] core_rx_data_o, // data to core
  input wire logic core_tx_valid_i, // data from core
  input wire logic [DATA_W-1:0] core_tx_data_i, // data from core
  output logic host_tx_valid_o, // data to host
  output logic [DATA_W-1:0] host_tx_data_o, // data to host
  input wire logic host_cmd_valid_i, // control from host
  input wire logic [DATA_W-1:0] host_cmd_i, // control word
  output logic core_cmd_valid_o, // control to core
  output logic [DATA_W-1:0] core_cmd_o, // control word
  input wire logic op_req_i, // crypto operation request
  output logic op_grant_o, // operation allowed pulse
  input wire logic login_fail_i, // failed login pulse
  input wire logic login_ok_i, // good login pulse
  output logic zeroize_o, // erase keys, passwords, seed, data
  output cstg_pkg::cstg_status_s status_o // status to host
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  cstg_pkg::cstg_state_e state_q, state_d;
  logic [2:0] sel_q, sel_d;
  logic [2:0] code_q, code_d;
  logic pass_q, err_q, perm_q, prior_q;
  logic [RNG_W-1:0] deterministic_random_generator_prev_q, noise_prev_q;
  logic deterministic_random_generator_seen_q, noise_seen_q;
  logic [`CSTG_FAIL_CNT_W-1:0] fails_q;
  logic ok_q;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  function automatic logic repeat_hit(input logic v, input logic seen,
                                      input logic [RNG_W-1:0] a, input logic [RNG_W-1:0] b);
    repeat_hit = v && seen && (a == b);
  endfunction

  wire deterministic_random_generator_rep = repeat_hit(deterministic_random_generator_valid_i, deterministic_random_generator_seen_q, deterministic_random_generator_data_i, deterministic_random_generator_prev_q);
  wire noise_rep = repeat_hit(noise_valid_i, noise_seen_q, noise_data_i, noise_prev_q);
  wire open_w = (state_q == cstg_pkg::CSTG_ST_RUN);
  wire kat_fail = (state_q == cstg_pkg::CSTG_ST_WAIT) && test_done_i && !test_pass_i;
  wire cont_fail = open_w && (deterministic_random_generator_rep || noise_rep);
  wire go_err = kat_fail || cont_fail;
  // data as well as valid is shut in the cycle a failure is seen
  wire gate_w = open_w && !go_err;
  wire limit_hit = login_fail_i && open_w &&
                   (fails_q == `CSTG_FAIL_CNT_W'(LOGIN_LIMIT - 1));

  always_comb begin
    state_d = state_q;
    sel_d = sel_q;
    code_d = code_q;
    case (state_q)
      cstg_pkg::CSTG_ST_LOAD: begin
        state_d = nv_rec_i.perm ? cstg_pkg::CSTG_ST_ERROR : cstg_pkg::CSTG_ST_START;
      end
      cstg_pkg::CSTG_ST_START: state_d = cstg_pkg::CSTG_ST_WAIT;
      cstg_pkg::CSTG_ST_WAIT: begin
        if (test_done_i) begin
          if (!test_pass_i) begin
            state_d = cstg_pkg::CSTG_ST_ERROR;
            code_d = sel_q;
          end else if (sel_q == `CSTG_TEST_LAST) begin
            state_d = cstg_pkg::CSTG_ST_RUN;
          end else begin
            sel_d = sel_q + 3'h1;
            state_d = cstg_pkg::CSTG_ST_START;
          end
        end
      end
      cstg_pkg::CSTG_ST_RUN: begin
        if (cont_fail) begin
          state_d = cstg_pkg::CSTG_ST_ERROR;
          code_d = deterministic_random_generator_rep ? `CSTG_TEST_CONT_DETERMINISTIC_RANDOM_GENERATOR : `CSTG_TEST_CONT_NOISE;
        end
      end
      cstg_pkg::CSTG_ST_ERROR: state_d = cstg_pkg::CSTG_ST_ERROR;
      default: state_d = cstg_pkg::CSTG_ST_ERROR;
    endcase
  end

  // ----------------------------------------------------------------
  // sequencer, only srst_i leaves the error state
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      state_q <= cstg_pkg::CSTG_ST_LOAD;
      sel_q <= `CSTG_TEST_FW_INTEGRITY;
      code_q <= 3'h0;
    end else begin
      state_q <= state_d;
      sel_q <= sel_d;
      code_q <= code_d;
    end
  end

  // result flags and nv record upkeep
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      prior_q <= 1'b0;
      pass_q <= 1'b0;
      err_q <= 1'b0;
      perm_q <= 1'b0;
      nv_wr_o <= 1'b0;
      nv_rec_o <= '0;
    end else begin
      nv_wr_o <= 1'b0;
      if (state_q == cstg_pkg::CSTG_ST_LOAD) begin
        prior_q <= nv_rec_i.err_seen;
        perm_q <= nv_rec_i.perm;
        err_q <= nv_rec_i.perm;
      end
      if (go_err) begin
        err_q <= 1'b1;
        pass_q <= 1'b0;
        perm_q <= kat_fail && prior_q;
        nv_rec_o <= '{err_seen: 1'b1, perm: kat_fail && prior_q};
        nv_wr_o <= 1'b1;
      end else if (state_q == cstg_pkg::CSTG_ST_WAIT && test_done_i && test_pass_i &&
                   sel_q == `CSTG_TEST_LAST) begin
        pass_q <= 1'b1;
        prior_q <= 1'b0;
        nv_rec_o <= '0;
        nv_wr_o <= prior_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // continuous rng comparison
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      deterministic_random_generator_prev_q <= '0;
      noise_prev_q <= '0;
      deterministic_random_generator_seen_q <= 1'b0;
      noise_seen_q <= 1'b0;
    end else begin
      if (deterministic_random_generator_valid_i) begin
        deterministic_random_generator_prev_q <= deterministic_random_generator_data_i;
        deterministic_random_generator_seen_q <= 1'b1;
      end
      if (noise_valid_i) begin
        noise_prev_q <= noise_data_i;
        noise_seen_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // login failure counter
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      fails_q <= '0;
      zeroize_o <= 1'b0;
    end else begin
      zeroize_o <= limit_hit;
      if (limit_hit || (login_ok_i && open_w)) begin
        fails_q <= '0;
      end else if (login_fail_i && open_w) begin
        fails_q <= fails_q + `CSTG_FAIL_CNT_W'(1);
      end
    end
  end

  // ----------------------------------------------------------------
  // gates on host link and crypto requests
  // ----------------------------------------------------------------
  // the host only ever sees core user data; no key store is wired to this path
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      ok_q <= 1'b0;
      core_rx_valid_o <= 1'b0;
      core_rx_data_o <= '0;
      host_tx_valid_o <= 1'b0;
      host_tx_data_o <= '0;
      core_cmd_valid_o <= 1'b0;
      core_cmd_o <= '0;
      op_grant_o <= 1'b0;
    end else begin
      ok_q <= gate_w;
      core_rx_valid_o <= host_rx_valid_i && gate_w;
      core_rx_data_o <= gate_w ? host_rx_data_i : '0;
      host_tx_valid_o <= core_tx_valid_i && gate_w;
      host_tx_data_o <= gate_w ? core_tx_data_i : '0;
      core_cmd_valid_o <= host_cmd_valid_i && gate_w;
      core_cmd_o <= gate_w ? host_cmd_i : '0;
      op_grant_o <= op_req_i && gate_w;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      test_start_o <= 1'b0;
      test_sel_o <= `CSTG_TEST_FW_INTEGRITY;
      status_o <= '{busy: 1'b1, pass: 1'b0, err: 1'b0, perm: 1'b0, code: 3'h0};
    end else begin
      test_start_o <= (state_d == cstg_pkg::CSTG_ST_START);
      test_sel_o <= sel_d;
      status_o <= '{busy: !(pass_q || err_q), pass: pass_q && ok_q, err: err_q, perm: perm_q, code: code_q};
    end
  end

endmodule // cstg_top

// ---- inc/cstg_cfg.svh ----
// constants for the crypto self-test and error gate
// assumes one clock domain and a synchronous power-on reset
//
// Summary of operation
// - after power-on run firmware integrity and known-answer tests with no operator action
// - once the power-up tests pass, continuously compare successive generator and noise outputs; a repeat is a failure
// - any failure enters the error state and raises an error status to the host
// - in the error state data in, data out and control in are shut
// - in the error state no cryptographic operation may start
// - only power cycling clears a non-permanent error, rerunning every power-up test; a permanent error runs none
// - a power-up test failure in the run following an error makes the error permanent; a repeat failure does not
// - no key or security parameter ever passes to or from the host
// - count failed logins and erase keys, passwords, seed and data at the limit
`ifndef CSTG_CFG_SVH
`define CSTG_CFG_SVH

// ----------------------------------------------------------------
// test identifiers; 0 to 5 run in this order, 6 and 7 name continuous-test failures
// ----------------------------------------------------------------
`define CSTG_TEST_FW_INTEGRITY 3'h0
`define CSTG_TEST_CIPHER_ENC 3'h1
`define CSTG_TEST_CIPHER_DEC 3'h2
`define CSTG_TEST_HASH_KAT 3'h3
`define CSTG_TEST_DETERMINISTIC_RANDOM_GENERATOR_KAT 3'h4
`define CSTG_TEST_KEYED_HASH 3'h5
`define CSTG_TEST_LAST 3'h5
`define CSTG_TEST_CONT_DETERMINISTIC_RANDOM_GENERATOR 3'h6
`define CSTG_TEST_CONT_NOISE 3'h7

// ----------------------------------------------------------------
// limits and widths
// ----------------------------------------------------------------
`define CSTG_LOGIN_LIMIT 20
`define CSTG_FAIL_CNT_W 5
`define CSTG_HASH_WIDE_BITS 512
`define CSTG_HASH_NARROW_BITS 256

`endif

// ---- inc/cstg_pkg.sv ----
// types shared by the self-test gate and its bench
// assumes cstg_cfg.svh supplies the constants
package cstg_pkg;

  typedef enum logic [2:0] {
    CSTG_ST_LOAD,
    CSTG_ST_START,
    CSTG_ST_WAIT,
    CSTG_ST_RUN,
    CSTG_ST_ERROR
  } cstg_state_e;

  // non-volatile fault record kept outside the block
  typedef struct packed {
    logic err_seen;
    logic perm;
  } cstg_nv_s;

  // status shown to the host
  typedef struct packed {
    logic busy;
    logic pass;
    logic err;
    logic perm;
    logic [2:0] code;
  } cstg_status_s;

endpackage

// ---- bench/cstg_engine_model.sv ----
// test engine model answering each start pulse after a set delay
// assumes start and select come from the gate on clock_i
`timescale 1ns/1ps
module cstg_engine_model (
  input wire logic clock_i, // clock
  input wire logic srst_i, // reset
  input wire logic start_i, // start pulse
  input wire logic [2:0] sel_i, // test id
  input wire logic [5:0] fail_i, // tests that fail
  input wire logic [3:0] lat_i, // answer delay
  output logic done_o, // done pulse
  output logic pass_o // result with done
);
  logic [3:0] cnt_q;
  logic [2:0] sel_q;
  logic run_q;
  // result toggles outside done so a stale value is never read as valid
  always_ff @(posedge clock_i) begin
    done_o <= 1'b0;
    pass_o <= ~pass_o;
    if (srst_i) begin
      run_q <= 1'b0;
      pass_o <= 1'b0;
    end else if (start_i) begin
      run_q <= 1'b1;
      cnt_q <= lat_i;
      sel_q <= sel_i;
    end else if (run_q && cnt_q == 4'h0) begin
      run_q <= 1'b0;
      done_o <= 1'b1;
      pass_o <= ~fail_i[sel_q];
    end else if (run_q) begin
      cnt_q <= cnt_q - 4'h1;
    end
  end
endmodule // cstg_engine_model

// ---- bench/cstg_top_sva.sv ----
// concurrent checks on the self-test gate ports
// assumes binding into cstg_top, single clock domain
`timescale 1ns/1ps
module cstg_top_sva #(
  parameter int DATA_W = 32,
  parameter int RNG_W = 64,
  parameter int LOGIN_LIMIT = 20
) (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic test_start_o,
  input wire logic [2:0] test_sel_o,
  input wire logic test_done_i,
  input wire logic test_pass_i,
  input wire logic deterministic_random_generator_valid_i,
  input wire logic [RNG_W-1:0] deterministic_random_generator_data_i,
  input wire logic host_rx_valid_i,
  input wire logic [DATA_W-1:0] host_rx_data_i,
  input wire logic core_rx_valid_o,
  input wire logic [DATA_W-1:0] core_rx_data_o,
  input wire logic host_tx_valid_o,
  input wire logic core_cmd_valid_o,
  input wire logic op_req_i,
  input wire logic op_grant_o,
  input wire logic login_fail_i,
  input wire logic zeroize_o,
  input wire cstg_pkg::cstg_status_s status_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);
  rx_pass_a: assert property (core_rx_valid_o |-> $past(host_rx_valid_i) && core_rx_data_o == $past(host_rx_data_i))
    else $error("rx pass wrong");
  err_gate_a: assert property (status_o.err |-> !core_rx_valid_o && !host_tx_valid_o && !core_cmd_valid_o)
    else $error("gate open in error");
  op_cause_a: assert property (op_grant_o |-> $past(op_req_i) && !$past(status_o.err))
    else $error("grant wrong");
  err_hold_a: assert property (status_o.err |=> status_o.err && !status_o.busy)
    else $error("error left");
  deterministic_random_generator_repeat_a:
    assert property (status_o.pass && !status_o.err && deterministic_random_generator_valid_i && $past(deterministic_random_generator_valid_i)
      && deterministic_random_generator_data_i == $past(deterministic_random_generator_data_i) |-> ##2 status_o.err && status_o.code == 3'h6) else $error("repeat missed");
  next_test_a:
    assert property (status_o.busy && test_done_i && test_pass_i && test_sel_o < 3'h5
      |=> test_start_o && test_sel_o == $past(test_sel_o) + 3'h1) else $error("next test wrong");
  fail_err_a: assert property (status_o.busy && test_done_i && !test_pass_i |-> ##2 status_o.err && !status_o.pass)
    else $error("fail not flagged");
  zero_cause_a: assert property (zeroize_o |-> $past(login_fail_i))
    else $error("zeroize without fail");
  start_pulse_a: assert property (test_start_o |=> !test_start_o)
    else $error("start too long");
endmodule // cstg_top_sva
bind cstg_top cstg_top_sva #(.DATA_W(DATA_W), .RNG_W(RNG_W), .LOGIN_LIMIT(LOGIN_LIMIT)) u_sva (.clock_i, .srst_i,
  .test_start_o, .test_sel_o, .test_done_i, .test_pass_i, .deterministic_random_generator_valid_i, .deterministic_random_generator_data_i, .host_rx_valid_i,
  .host_rx_data_i, .core_rx_valid_o, .core_rx_data_o, .host_tx_valid_o, .core_cmd_valid_o, .op_req_i, .op_grant_o,
  .login_fail_i, .zeroize_o, .status_o);

// ---- bench/crypto_selftest_error_gate_tb.sv ----
// self-checking bench for the self-test gate
// assumes the engine model stands in for the test engines
`timescale 1ns/1ps
`include "cstg_cfg.svh"
module crypto_selftest_error_gate_tb;
  logic clock_i, srst_i, dv, nzv, hv, tv, mv, op, lf, lo, traf, mon, opn, done, pass, nvw, ts, rv, xv, cv, gr, zz;
  logic [2:0] nvr;
  logic [1:0] rpt;
  logic [3:0] lat, ev_q;
  logic [2:0] sel;
  logic [5:0] fail;
  logic [31:0] hd, td, md, rd, xd, cd, hd_q, td_q, md_q, err_count, compares, zc, sc;
  logic [63:0] dd, nd;
  cstg_pkg::cstg_nv_s nv_rec, nvo;
  cstg_pkg::cstg_status_s st;
  cstg_top #(.LOGIN_LIMIT(3)) u_dut (.clock_i, .srst_i, .nv_rec_i(nv_rec), .nv_rec_o(nvo), .nv_wr_o(nvw),
    .test_start_o(ts), .test_sel_o(sel), .test_done_i(done), .test_pass_i(pass), .deterministic_random_generator_valid_i(dv), .deterministic_random_generator_data_i(dd),
    .noise_valid_i(nzv), .noise_data_i(nd), .host_rx_valid_i(hv), .host_rx_data_i(hd), .core_rx_valid_o(rv),
    .core_rx_data_o(rd), .core_tx_valid_i(tv), .core_tx_data_i(td), .host_tx_valid_o(xv), .host_tx_data_o(xd),
    .host_cmd_valid_i(mv), .host_cmd_i(md), .core_cmd_valid_o(cv), .core_cmd_o(cd), .op_req_i(op), .op_grant_o(gr),
    .login_fail_i(lf), .login_ok_i(lo), .zeroize_o(zz), .status_o(st));
  cstg_engine_model u_eng (.clock_i, .srst_i, .start_i(ts), .sel_i(sel), .fail_i(fail), .lat_i(lat), .done_o(done),
    .pass_o(pass));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wrap_up();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic boot(input logic [1:0] rec, input logic [5:0] f, input logic [3:0] l);
    int n;
    @(posedge clock_i);
    {nv_rec, fail, lat, srst_i} <= {rec, f, l, 1'b1};
    repeat (8) @(posedge clock_i);
    srst_i <= 1'b0;
    for (n = 0; n < 400 && st.busy !== 1'b0; n++) @(negedge clock_i);
    if (n == 400) begin
      chk("boot_wait", 0, 1);
      wrap_up();
    end
    repeat (2) @(negedge clock_i);
  endtask
  task automatic traffic(input logic o);
    @(posedge clock_i);
    {traf, opn} <= {1'b1, o};
    @(posedge clock_i);
    mon <= 1'b1;
    repeat (60) @(posedge clock_i);
    {traf, mon} <= 2'b00;
  endtask
  task automatic rep(input logic w);
    @(posedge clock_i);
    rpt <= w ? 2'b10 : 2'b01;
    repeat (2) @(posedge clock_i);
    rpt <= 2'b00;
    repeat (4) @(negedge clock_i);
  endtask
  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end
  // random traffic and generator words; rpt forces two equal words
  always @(posedge clock_i) begin
    {hv, tv, mv, op} <= traf ? 4'($urandom) : 4'h0;
    dv <= rpt[0] || (traf && $urandom_range(1));
    nzv <= rpt[1] || (traf && $urandom_range(1));
    dd <= rpt[0] ? 64'h5A5A_0F0F_3C3C_9696 : {$urandom, $urandom};
    nd <= rpt[1] ? 64'hC3C3_1E1E_7878_0F0F : {$urandom, $urandom};
    {hd, td, md} <= {$urandom, $urandom, $urandom};
    ev_q <= {hv, tv, mv, op};
    hd_q <= hd;
    td_q <= td;
    md_q <= md;
    sc <= srst_i ? 32'h0 : sc + ts;
    zc <= srst_i ? 32'h0 : zc + zz;
    nvr <= srst_i ? 3'h0 : (nvw ? {1'b1, nvo} : nvr);
  end
  always @(negedge clock_i) begin
    if (mon) begin
      chk("rx_valid", opn & ev_q[3], rv);
      chk("tx_valid", opn & ev_q[2], xv);
      chk("cmd_valid", opn & ev_q[1], cv);
      chk("op_grant", opn & ev_q[0], gr);
      chk("rx_data", opn ? hd_q : 32'h0, rd);
      chk("tx_data", opn ? td_q : 32'h0, xd);
      chk("cmd_data", opn ? md_q : 32'h0, cd);
    end
  end
  initial begin
    {lf, lo, traf, mon, opn, rpt, lat, fail, nv_rec, err_count, compares} = '0;
    srst_i = 1'b1;
    void'($urandom(35331));
    boot(2'b00, 6'h00, 4'h0);
    chk("pass", 1, st.pass);
    chk("starts", 6, sc);
    chk("nv_idle", 0, nvr);
    traffic(1'b1);
    for (int i = 0; i < 6; i++) begin
      @(posedge clock_i);
      {lf, lo} <= (i == 2) ? 2'b01 : 2'b10;
      @(posedge clock_i);
      {lf, lo} <= 2'b00;
    end
    repeat (3) @(negedge clock_i);
    chk("zeroize", 1, zc);
    rep(1'b0);
    chk("deterministic_random_generator_err", {1'b1, `CSTG_TEST_CONT_DETERMINISTIC_RANDOM_GENERATOR}, {st.err, st.code});
    traffic(1'b0);
    boot(2'b00, 6'h04, 4'($urandom));
    chk("fail_err", 2, {st.err, st.perm});
    chk("fail_code", 2, st.code);
    chk("stop_first", 3, sc);
    chk("nv_rec", 6, nvr);
    boot(2'b10, 6'h01, 4'($urandom));
    chk("perm_err", 3, {st.err, st.perm});
    chk("nv_perm", 7, nvr);
    boot(2'b01, 6'h00, 4'($urandom));
    chk("perm_boot", 3, {st.err, st.perm});
    chk("no_tests", 0, sc);
    chk("nv_none", 0, nvr);
    boot(2'b10, 6'h00, 4'($urandom));
    chk("pass_again", 1, st.pass);
    chk("nv_clear", 4, nvr);
    rep(1'b1);
    chk("noise_err", {1'b1, `CSTG_TEST_CONT_NOISE}, {st.err, st.code});
    chk("cont_perm", 6, nvr);
    wrap_up();
  end
endmodule // crypto_selftest_error_gate_tb
